// ### rtl/sdf_device.sv
// sensor end: serves measurement packets over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module sdf_device (
    input  wire logic                           i_clk,
    input  wire logic                           i_nrst,
    input  wire logic                           i_en,
    sdf_if.device                               bus,
    input  wire logic [6:0]                     i_target_addr,
    input  wire logic [sdf_pkg::SDF_PRESS_W-1:0] i_press,
    input  wire logic [sdf_pkg::SDF_TEMP_W-1:0]  i_temp,
    input  wire logic                           i_meas_done,
    input  wire logic                           i_cmd_mode,
    input  wire logic                           i_fault,
    output logic      [1:0]                     o_status,
    output logic                                o_busy,
    output logic                                o_fetch
);
    import sdf_pkg::*;

    typedef enum logic [5:0] {
        SDF_D_IDLE = 6'h01,
        SDF_D_ADDR = 6'h02,
        SDF_D_AACK = 6'h04,
        SDF_D_TX   = 6'h08,
        SDF_D_RACK = 6'h10,
        SDF_D_IGN  = 6'h20
    } sdf_dstate_t;

    function automatic logic [7:0] sdf_pkt_byte(input logic [2:0] idx,
                                                 input logic [1:0] st,
                                                 input logic [SDF_PRESS_W-1:0] p,
                                                 input logic [SDF_TEMP_W-1:0] t);
        logic [7:0] b;
        b = SDF_PAD_BYTE;
        case (idx)
            3'h0:    b = {st, p[13:8]};
            3'h1:    b = p[7:0];
            3'h2:    b = t[10:3];
            3'h3:    b = {t[2:0], SDF_PAD_BITS};
            default: b = SDF_PAD_BYTE;
        endcase
        return b;
    endfunction : sdf_pkt_byte

    sdf_dstate_t            state, next_state;
    logic [2:0]             scl_s, next_scl_s;
    logic [2:0]             sda_s, next_sda_s;
    logic                   scl_f, sda_f;
    logic                   scl_new, sda_new;
    logic [3:0]             bitcnt, next_bitcnt;
    logic [7:0]             shreg, next_shreg;
    logic [2:0]             byte_idx, next_byte_idx;
    logic                   sda_oe, next_sda_oe;
    logic                   ack_n, next_ack_n;
    logic                   poison, next_poison;
    logic                   seen_clk, next_seen_clk;
    logic                   stale, next_stale;
    logic                   fault_lat, next_fault_lat;
    logic [SDF_PRESS_W-1:0] press_q, next_press_q;
    logic [SDF_TEMP_W-1:0]  temp_q, next_temp_q;
    logic [1:0]             snap_st, next_snap_st;
    logic [SDF_PRESS_W-1:0] snap_p, next_snap_p;
    logic [SDF_TEMP_W-1:0]  snap_t, next_snap_t;
    logic [1:0]             code, next_code;
    logic                   fetch, next_fetch;
    logic                   scl_rise, scl_fall;
    logic                   start, stop;
    logic [7:0]             nb;

    always_comb begin
        // filtered pin levels: second and third stage must agree
        scl_new  = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
        sda_new  = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
        scl_rise = !scl_f && scl_new;
        scl_fall = scl_f && !scl_new;
        start    = scl_f && scl_new && sda_f && !sda_new;
        stop     = scl_f && scl_new && !sda_f && sda_new;
        nb       = SDF_PAD_BYTE;

        next_scl_s     = {scl_s[1:0], bus.scl};
        next_sda_s     = {sda_s[1:0], bus.sda};
        next_state     = state;
        next_bitcnt    = bitcnt;
        next_shreg     = shreg;
        next_byte_idx  = byte_idx;
        next_sda_oe    = sda_oe;
        next_ack_n     = ack_n;
        next_poison    = poison;
        next_seen_clk  = seen_clk || scl_rise;
        next_stale     = stale;
        next_fault_lat = fault_lat;
        next_press_q   = press_q;
        next_temp_q    = temp_q;
        next_snap_st   = snap_st;
        next_snap_p    = snap_p;
        next_snap_t    = snap_t;
        next_fetch     = 1'b0;

        // status code to send now
        next_code = fault_lat  ? SDF_ST_FAULT :
                    i_cmd_mode ? SDF_ST_CMD   :
                    stale      ? SDF_ST_STALE :
                                 SDF_ST_GOOD;

        // measurement cycle completion
        if (i_meas_done) begin
            next_press_q = i_press;
            next_temp_q  = i_temp;
            next_stale   = 1'b0;
            if (i_fault) begin
                next_fault_lat = 1'b1;
            end
        end

        if (start) begin
            next_seen_clk = 1'b0;
            next_bitcnt   = 4'h0;
            next_sda_oe   = 1'b0;
            if (poison) begin
                next_poison = 1'b0;
                next_state  = SDF_D_IGN;
            end else if (state != SDF_D_IDLE && state != SDF_D_IGN) begin
                next_state  = SDF_D_IGN;
            end else begin
                next_state  = SDF_D_ADDR;
            end
        end else if (stop) begin
            if (!seen_clk) begin
                next_poison = 1'b1;
            end
            next_sda_oe = 1'b0;
            next_state  = SDF_D_IDLE;
        end else begin
            case (state)
                SDF_D_ADDR: begin
                    if (scl_rise) begin
                        next_shreg  = {shreg[6:0], sda_new};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == SDF_BITS_BYTE) begin
                        if (shreg[7:1] == i_target_addr && shreg[0] == SDF_RW_READ) begin
                            next_state   = SDF_D_AACK;
                            next_sda_oe  = 1'b1;
                            next_snap_st = code;
                            next_snap_p  = press_q;
                            next_snap_t  = temp_q;
                            next_stale   = 1'b1;
                            next_fetch   = 1'b1;
                        end else begin
                            next_state   = SDF_D_IGN;
                        end
                    end
                end
                SDF_D_AACK: begin
                    if (scl_fall) begin
                        nb            = sdf_pkt_byte(3'h0, snap_st, snap_p, snap_t);
                        next_shreg    = nb;
                        next_byte_idx = 3'h1;
                        next_bitcnt   = 4'h0;
                        next_sda_oe   = !nb[7];
                        next_state    = SDF_D_TX;
                    end
                end
                SDF_D_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == SDF_BITS_BYTE - 4'h1) begin
                            next_sda_oe = 1'b0;
                            next_state  = SDF_D_RACK;
                        end else begin
                            next_shreg  = {shreg[6:0], 1'b0};
                            next_sda_oe = !shreg[6];
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                SDF_D_RACK: begin
                    if (scl_rise) begin
                        next_ack_n = sda_new;
                    end else if (scl_fall) begin
                        if (!ack_n) begin
                            nb          = sdf_pkt_byte(byte_idx, snap_st, snap_p, snap_t);
                            next_shreg  = nb;
                            next_sda_oe = !nb[7];
                            next_bitcnt = 4'h0;
                            next_state  = SDF_D_TX;
                            if (byte_idx != SDF_LEN_MAX) begin
                                next_byte_idx = byte_idx + 3'h1;
                            end
                        end else begin
                            next_state  = SDF_D_IDLE;
                        end
                    end
                end
                SDF_D_IDLE, SDF_D_IGN: ;
                default: next_state = SDF_D_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state     <= SDF_D_IDLE;
            scl_s     <= 3'h7;
            sda_s     <= 3'h7;
            scl_f     <= 1'b1;
            sda_f     <= 1'b1;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            byte_idx  <= 3'h0;
            sda_oe    <= 1'b0;
            ack_n     <= 1'b1;
            poison    <= 1'b0;
            seen_clk  <= 1'b0;
            stale     <= 1'b1;
            fault_lat <= 1'b0;
            press_q   <= '0;
            temp_q    <= '0;
            snap_st   <= SDF_ST_STALE;
            snap_p    <= '0;
            snap_t    <= '0;
            code      <= SDF_ST_STALE;
            fetch     <= 1'b0;
        end else if (i_en) begin
            state     <= next_state;
            scl_s     <= next_scl_s;
            sda_s     <= next_sda_s;
            scl_f     <= scl_new;
            sda_f     <= sda_new;
            bitcnt    <= next_bitcnt;
            shreg     <= next_shreg;
            byte_idx  <= next_byte_idx;
            sda_oe    <= next_sda_oe;
            ack_n     <= next_ack_n;
            poison    <= next_poison;
            seen_clk  <= next_seen_clk;
            stale     <= next_stale;
            fault_lat <= next_fault_lat;
            press_q   <= next_press_q;
            temp_q    <= next_temp_q;
            snap_st   <= next_snap_st;
            snap_p    <= next_snap_p;
            snap_t    <= next_snap_t;
            code      <= next_code;
            fetch     <= next_fetch;
        end
    end

    assign bus.sda_d_o  = 1'b0;
    assign bus.sda_d_oe = sda_oe;
    assign o_status     = code;
    assign o_fetch      = fetch;
    assign o_busy       = (state != SDF_D_IDLE) && (state != SDF_D_IGN);
endmodule : sdf_device
`default_nettype wire

// ### pkg/sdf_pkg.sv
// shared constants for the sensor data fetch link
package sdf_pkg;
    localparam int          SDF_CLK_HZ       = 25_000_000;
    localparam int          SDF_SCL_HZ       = 100_000;
    localparam int          SDF_QTR_CYC      = SDF_CLK_HZ / (SDF_SCL_HZ * 4);
    localparam int          SDF_QTR_W        = 7;
    localparam int          SDF_PRESS_W      = 14;
    localparam int          SDF_TEMP_W       = 11;
    localparam logic [6:0]  SDF_ADDR_DEFAULT = 7'h28;
    localparam logic        SDF_RW_READ      = 1'h1;
    localparam logic [1:0]  SDF_ST_GOOD      = 2'h0;
    localparam logic [1:0]  SDF_ST_CMD       = 2'h1;
    localparam logic [1:0]  SDF_ST_STALE     = 2'h2;
    localparam logic [1:0]  SDF_ST_FAULT     = 2'h3;
    localparam logic [2:0]  SDF_LEN_MIN      = 3'h2;
    localparam logic [2:0]  SDF_LEN_MAX      = 3'h4;
    localparam logic [3:0]  SDF_BITS_BYTE    = 4'h8;
    localparam logic [4:0]  SDF_PAD_BITS     = 5'h00;
    localparam logic [7:0]  SDF_PAD_BYTE     = 8'h00;
endpackage : sdf_pkg

// ### pkg/sdf_if.sv
// open-drain two-wire link between fetch master and sensor end
`timescale 1ns/100ps
`default_nettype none
interface sdf_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic scl;
    logic sda;
    // pull-up wins unless a driver pulls low
    assign scl = !(scl_oe && !scl_o);
    assign sda = !(sda_m_oe && !sda_m_o) && !(sda_d_oe && !sda_d_o);
    modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                    input scl, input sda);
    modport device (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface : sdf_if
`default_nettype wire

// ### rtl/sdf_master.sv
// fetch master: clocks out a read header and collects 2 to 4 bytes
`timescale 1ns/100ps
`default_nettype none
module sdf_master (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_en,
    sdf_if.master            bus,
    input  wire logic        i_go,
    input  wire logic [6:0]  i_target_addr,
    input  wire logic [2:0]  i_len,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_addr_nack,
    output logic [31:0]      o_rx_data
);
    import sdf_pkg::*;

    typedef enum logic [3:0] {
        SDF_M_IDLE  = 4'h1,
        SDF_M_START = 4'h2,
        SDF_M_BIT   = 4'h4,
        SDF_M_STOP  = 4'h8
    } sdf_mstate_t;

    sdf_mstate_t          state;
    sdf_mstate_t          next_state;
    logic [SDF_QTR_W-1:0] qcnt;
    logic [SDF_QTR_W-1:0] next_qcnt;
    logic [1:0]           phase;
    logic [1:0]           next_phase;
    logic [3:0]           bitcnt;
    logic [3:0]           next_bitcnt;
    logic [2:0]           bytecnt;
    logic [2:0]           next_bytecnt;
    logic [2:0]           len;
    logic [2:0]           next_len;
    logic [7:0]           txb;
    logic [7:0]           next_txb;
    logic [31:0]          rx;
    logic [31:0]          next_rx;
    logic                 scl_hi;
    logic                 next_scl_hi;
    logic                 sda_lo;
    logic                 next_sda_lo;
    logic                 nack;
    logic                 next_nack;
    logic                 done;
    logic                 next_done;
    logic [2:0]           sda_s;
    logic                 sda_f;
    logic                 sda_new;
    logic                 tick;

    always_comb begin
        sda_new      = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
        tick         = (qcnt == SDF_QTR_W'(SDF_QTR_CYC - 1));
        next_state   = state;
        next_qcnt    = tick ? '0 : qcnt + 1'b1;
        next_phase   = tick ? phase + 2'h1 : phase;
        next_bitcnt  = bitcnt;
        next_bytecnt = bytecnt;
        next_len     = len;
        next_txb     = txb;
        next_rx      = rx;
        next_scl_hi  = scl_hi;
        next_sda_lo  = sda_lo;
        next_nack    = nack;
        next_done    = 1'b0;
        case (state)
            SDF_M_IDLE: begin
                next_qcnt   = '0;
                next_phase  = 2'h0;
                next_scl_hi = 1'b1;
                next_sda_lo = 1'b0;
                if (i_go) begin
                    next_len     = (i_len < SDF_LEN_MIN) ? SDF_LEN_MIN :
                                   (i_len > SDF_LEN_MAX) ? SDF_LEN_MAX : i_len;
                    next_txb     = {i_target_addr, SDF_RW_READ};
                    next_bitcnt  = 4'h0;
                    next_bytecnt = 3'h0;
                    next_nack    = 1'b0;
                    next_rx      = '0;
                    next_state   = SDF_M_START;
                end
            end
            SDF_M_START: begin
                if (tick) begin
                    if (phase == 2'h0) begin
                        next_sda_lo = 1'b1;
                    end else begin
                        next_scl_hi = 1'b0;
                        next_phase  = 2'h0;
                        next_state  = SDF_M_BIT;
                    end
                end
            end
            SDF_M_BIT: begin
                if (tick) begin
                    case (phase)
                        2'h0: begin
                            if (bitcnt == SDF_BITS_BYTE) begin
                                // ack while more bytes are wanted
                                next_sda_lo = (bytecnt != 3'h0) && (bytecnt < len);
                            end else if (bytecnt == 3'h0) begin
                                next_sda_lo = !txb[7];
                            end else begin
                                next_sda_lo = 1'b0;
                            end
                        end
                        2'h1: next_scl_hi = 1'b1;
                        2'h2: begin
                            if (bitcnt == SDF_BITS_BYTE && bytecnt == 3'h0) begin
                                next_nack = sda_new;
                            end else if (bitcnt != SDF_BITS_BYTE && bytecnt != 3'h0) begin
                                next_rx = {rx[30:0], sda_new};
                            end
                        end
                        default: begin
                            next_scl_hi = 1'b0;
                            if (bitcnt == SDF_BITS_BYTE) begin
                                next_bitcnt = 4'h0;
                                if ((bytecnt == 3'h0 && nack) || bytecnt == len) begin
                                    next_state = SDF_M_STOP;
                                end else begin
                                    next_bytecnt = bytecnt + 3'h1;
                                end
                            end else begin
                                next_bitcnt = bitcnt + 4'h1;
                                next_txb    = {txb[6:0], 1'b0};
                            end
                        end
                    endcase
                end
            end
            SDF_M_STOP: begin
                if (tick) begin
                    case (phase)
                        2'h0:    next_sda_lo = 1'b1;
                        2'h1:    next_scl_hi = 1'b1;
                        2'h2:    next_sda_lo = 1'b0;
                        default: begin
                            next_done  = 1'b1;
                            next_state = SDF_M_IDLE;
                        end
                    endcase
                end
            end
            default: next_state = SDF_M_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state   <= SDF_M_IDLE;
            qcnt    <= '0;
            phase   <= 2'h0;
            bitcnt  <= 4'h0;
            bytecnt <= 3'h0;
            len     <= SDF_LEN_MIN;
            txb     <= 8'h00;
            rx      <= '0;
            scl_hi  <= 1'b1;
            sda_lo  <= 1'b0;
            nack    <= 1'b0;
            done    <= 1'b0;
            sda_s   <= 3'h7;
            sda_f   <= 1'b1;
        end else if (i_en) begin
            state   <= next_state;
            qcnt    <= next_qcnt;
            phase   <= next_phase;
            bitcnt  <= next_bitcnt;
            bytecnt <= next_bytecnt;
            len     <= next_len;
            txb     <= next_txb;
            rx      <= next_rx;
            scl_hi  <= next_scl_hi;
            sda_lo  <= next_sda_lo;
            nack    <= next_nack;
            done    <= next_done;
            sda_s   <= {sda_s[1:0], bus.sda};
            sda_f   <= sda_new;
        end
    end

    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = !scl_hi;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = sda_lo;
    assign o_busy       = (state != SDF_M_IDLE);
    assign o_done       = done;
    assign o_addr_nack  = nack;
    assign o_rx_data    = rx;
endmodule : sdf_master
`default_nettype wire

// ### testbench/sdf_link_asserts.sv
// assertions on the two-wire fetch link
`timescale 1ns/100ps
`default_nettype none
module sdf_link_asserts (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [8:0] lo_cnt, hi_cnt, next_lo, next_hi;
    always_comb begin
        next_lo = scl ? 9'h000 : lo_cnt + 9'h001;
        next_hi = scl ? hi_cnt + {8'h00, ~&hi_cnt} : 9'h000;
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) {lo_cnt, hi_cnt} <= '0;
        else {lo_cnt, hi_cnt} <= {next_lo, next_hi};
    end
    // window from start condition to first clock rise
    logic sda_q, scl_q, hdr_win;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {sda_q, scl_q, hdr_win} <= 3'h6;
        end else begin
            sda_q   <= sda;
            scl_q   <= scl;
            hdr_win <= (scl && scl_q && sda_q && !sda) || (hdr_win && !(scl && !scl_q));
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    od_low_a: assert property (!scl_o && !sda_m_o && !sda_d_o)
        else $error("driven level not low");
    reset_idle_a: assert property ($rose(i_nrst) |-> !scl_oe && !sda_m_oe && !sda_d_oe)
        else $error("bus not idle after reset");
    scl_low_a: assert property ($rose(scl) |-> lo_cnt >= 9'h078)
        else $error("clock low too short");
    scl_high_a: assert property ($fell(scl) |-> hi_cnt >= 9'h03C)
        else $error("clock high too short");
    dev_lag_a: assert property ($changed(sda_d_oe) |-> !scl && lo_cnt inside {[9'h001:9'h008]})
        else $error("sensor data moved off clock low");
    dev_hold_a: assert property ($rose(scl) |-> $stable(sda_d_oe) [*8])
        else $error("sensor data moved in clock high");
    start_own_a: assert property (scl && $fell(sda) |-> sda_m_oe)
        else $error("start not made by master");
    stop_own_a: assert property (scl && $past(scl) && $rose(sda) |-> $past(sda_m_oe))
        else $error("stop not made by master");
    hdr_fall_a: assert property (hdr_win |-> !$fell(sda))
        else $error("data fell before first clock rise");
    one_drv_a: assert property (scl && sda_d_oe |-> !sda_m_oe)
        else $error("both ends drive data in clock high");
    start_c: cover property (scl && $fell(sda));
    dev_drive_c: cover property ($rose(sda_d_oe));
    stop_c: cover property (scl && $rose(sda));
endmodule : sdf_link_asserts
`default_nettype wire

// ### testbench/sensor_data_fetch_i2c_slave_tb.sv
// self-checking bench: fetch master and sensor end on one link
`timescale 1ns/100ps
`default_nettype none
module sensor_data_fetch_i2c_slave_tb;
    import sdf_pkg::*;
    typedef struct packed {
        logic [2:0] len; logic cmd; logic [13:0] press; logic [10:0] temp; logic [1:0] st;
    } sdf_row_t;
    localparam sdf_row_t ROWS [3] = '{'{3'h2, 1'h0, 14'h2A5C, 11'h5B3, 2'h0},
        '{3'h3, 1'h1, 14'h1F01, 11'h7FF, 2'h1}, '{3'h4, 1'h0, 14'h3FFF, 11'h455, 2'h0}};
    logic i_clk, i_nrst, go, meas, cmd, fault, done, nack;
    logic [2:0] len;
    logic [6:0] addr;
    logic [13:0] press;
    logic [10:0] temp;
    logic [1:0] st;
    logic [31:0] rx;
    logic mbusy, dbusy, dfetch;
    int miscompares = 0, num_checks = 0, cyc = 0, fetches = 0;
    sdf_if lnk ();
    sdf_master i_sdf_master (.i_clk(i_clk), .i_nrst(i_nrst), .i_en(1'h1), .bus(lnk.master),
        .i_go(go), .i_target_addr(addr), .i_len(len), .o_busy(mbusy), .o_done(done),
        .o_addr_nack(nack), .o_rx_data(rx));
    sdf_device i_sdf_device (.i_clk(i_clk), .i_nrst(i_nrst), .i_en(1'h1), .bus(lnk.device),
        .i_target_addr(SDF_ADDR_DEFAULT), .i_press(press), .i_temp(temp), .i_meas_done(meas),
        .i_cmd_mode(cmd), .i_fault(fault), .o_status(st), .o_busy(dbusy), .o_fetch(dfetch));
    sdf_link_asserts i_sdf_link_asserts (.i_clk(i_clk), .i_nrst(i_nrst), .scl_o(lnk.scl_o),
        .scl_oe(lnk.scl_oe), .sda_m_o(lnk.sda_m_o), .sda_m_oe(lnk.sda_m_oe),
        .sda_d_o(lnk.sda_d_o), .sda_d_oe(lnk.sda_d_oe), .scl(lnk.scl), .sda(lnk.sda));
    function automatic logic [31:0] pk(input sdf_row_t r);
        logic [31:0] w;
        w = {r.st, r.press, r.temp, 5'h00};
        return w >> (8 * (4 - int'(r.len)));
    endfunction : pk
    task automatic chk(input logic [31:0] seen, input logic [31:0] e, input string m);
        num_checks++;
        if (seen !== e) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // one measurement cycle with new data
    task automatic sample(input sdf_row_t r, input logic f);
        @(negedge i_clk);
        {press, temp, cmd, fault, meas} = {r.press, r.temp, r.cmd, f, 1'h1};
        @(negedge i_clk);
        meas = 1'h0;
    endtask : sample
    task automatic fetch(input logic [2:0] n, input logic [6:0] a);
        int k;
        @(negedge i_clk);
        {len, addr, go} = {n, a, 1'h1};
        @(negedge i_clk);
        go = 1'h0;
        for (k = 0; k < 20000 && done !== 1'h1; k++) @(negedge i_clk);
        chk(done, 1'h1, "done");
        chk({mbusy, dbusy}, 2'h0, "busy after stop");
    endtask : fetch
    initial begin
        i_clk = 1'h0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 80000) begin
            miscompares++;
            close_out();
        end
    end
    // count acknowledged read headers
    always @(negedge i_clk) begin
        if (dfetch === 1'h1) begin
            fetches++;
        end
    end
    initial begin
        {i_nrst, go, meas, cmd, fault, len, addr, press, temp} = '0;
        repeat (8) @(negedge i_clk);
        i_nrst = 1'h1;
        foreach (ROWS[i]) begin
            sample(ROWS[i], 1'h0);
            fetch(ROWS[i].len, SDF_ADDR_DEFAULT);
            chk(rx, pk(ROWS[i]), "packet");
            $display("row %0d done", i);
        end
        fetch(3'h2, SDF_ADDR_DEFAULT);
        chk(rx[15:14], SDF_ST_STALE, "second fetch");
        sample(ROWS[0], 1'h1);
        sample(ROWS[2], 1'h0);
        fetch(3'h2, SDF_ADDR_DEFAULT);
        chk(rx[15:14], SDF_ST_FAULT, "fault held");
        $display("stale and fault done");
        i_nrst = 1'h0;
        repeat (8) @(negedge i_clk);
        chk(st, SDF_ST_STALE, "reset status");
        chk(rx, 32'h0, "reset data");
        chk({nack, done, mbusy, dbusy, dfetch}, 5'h00, "reset outputs");
        i_nrst = 1'h1;
        fetch(3'h2, SDF_ADDR_DEFAULT);
        chk(rx[15:14], SDF_ST_STALE, "first fetch");
        fetch(3'h2, SDF_ADDR_DEFAULT ^ 7'h01);
        chk(nack, 1'h1, "other address");
        chk(rx, 32'h0, "no data for other address");
        chk(fetches, 6, "header acks");
        $display("reset and address done");
        close_out();
    end
endmodule : sensor_data_fetch_i2c_slave_tb
`default_nettype wire
